// ===== dv/bidirectional_gpio_port_test.sv
`include "gpio_port_consts.svh"
module bidirectional_gpio_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] pad_in, pad_out, pad_oe, slew, thr, pup, ana, periph, i2c, ext_en, ext_val;
  logic [7:0] l, a, e, o, m;
  logic [33:0] bq[$], rq[$];
  int n_errors = 0;
  int checks = 0;
  integer seed;

  gpio_port u_gpio_port (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .slew_limit_o(slew), .threshold_ttl_o(thr),
    .pullup_en_o(pup), .analog_en_o(ana), .periph_out_i(periph), .i2c_own_i(i2c));

  pad_board u_pad_board (.core_clk_i(core_clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pullup_en_i(pup), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in));

  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic check_bus(input string what, input logic [33:0] exp, input logic [33:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_bus

  task automatic check_pad(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_pad

  // bus answers are matched against the oldest note while the handshake is up;
  // an answer with no note gets an impossible one, so it still counts as a mismatch
  always @(negedge core_clk_i)
  begin
    if (bvalid !== 1'b0 && bready)
    begin
      if (bq.size() == 0)
        bq.push_back(34'h3_ffff_ffff);
      check_bus("write response", bq.pop_front(), {bresp, 32'h0000_0000});
    end
    if (rvalid !== 1'b0 && rready)
    begin
      if (rq.size() == 0)
        rq.push_back(34'h3_ffff_ffff);
      check_bus("read data", rq.pop_front(), {rresp, rdata});
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask : cyc

  // handshakes are judged mid-cycle, where ready has settled from the last edge
  task automatic wr(input logic [5:0] ad, input logic [7:0] d, input logic [3:0] s,
    input logic [1:0] er = `RESP_OKAY);
    logic ta, tw, tb;
    bq.push_back({er, 32'h0000_0000});
    awaddr <= ad;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    tb = 1'b0;
    while (!tb) // no cycle count assumed; a hang is left to the watchdog
    begin
      @(negedge core_clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge core_clk_i);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [5:0] ad, input logic [7:0] ed,
    input logic [1:0] er = `RESP_OKAY);
    logic ta, tb;
    rq.push_back({er, 24'h00_0000, ed});
    araddr <= ad;
    arvalid <= 1'b1;
    tb = 1'b0;
    while (!tb) // no cycle count assumed; a hang is left to the watchdog
    begin
      @(negedge core_clk_i);
      ta = arvalid && arready;
      tb = rvalid && rready;
      @(posedge core_clk_i);
      if (ta)
        arvalid <= 1'b0;
    end
  endtask : rd

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // cuts a hang short well past the hundred and thirty or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    finish_test();
  end

  initial
  begin
    seed = 32'h772e_da8e;
    {rst_n_i, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    {periph, i2c, ext_en, ext_val} = '0;
    bready = 1'b1;
    rready = 1'b1;
    cyc(16);
    rst_n_i <= 1'b1;
    @(negedge core_clk_i);
    check_pad("pad enable", 8'h00, pad_oe);
    check_pad("analog", 8'hFF, ana);
    check_pad("pull-up", 8'h00, pup);
    @(posedge core_clk_i);
    rd(`OFS_PIN_VALUE, 8'h00);
    rd(`OFS_DIRECTION, 8'hFF);
    rd(`OFS_OUT_LATCH, 8'h00);
    rd(`OFS_ANALOG_SEL, 8'hFF);
    rd(`OFS_PULLUP, 8'h00);
    rd(`OFS_OPEN_DRAIN, 8'h00);
    rd(`OFS_SLEW, 8'h00);
    rd(`OFS_THRESHOLD, 8'h00);
    rd(`OFS_PERIPH_SEL, 8'h00);
    rd(6'h24, 8'h00, `RESP_SLVERR);
    rd(6'h06, 8'h00, `RESP_SLVERR);
    wr(6'h24, 8'hA5, 4'h1, `RESP_SLVERR);
    end_test("reset");
    // outputs stay digital even with analog mode still on every pin
    l = 8'($random(seed));
    wr(`OFS_OUT_LATCH, l, 4'h1);
    wr(`OFS_DIRECTION, 8'h00, 4'h1);
    cyc(2);
    @(negedge core_clk_i);
    check_pad("pad enable", 8'hFF, pad_oe);
    check_pad("pad level", l, pad_out);
    check_pad("analog", 8'hFF, ana);
    @(posedge core_clk_i);
    wr(`OFS_DIRECTION, 8'hFF, 4'h1);
    cyc(2);
    @(negedge core_clk_i);
    check_pad("pad enable", 8'h00, pad_oe);
    @(posedge core_clk_i);
    end_test("drive");
    a = 8'($random(seed));
    e = 8'($random(seed));
    wr(`OFS_ANALOG_SEL, a, 4'h1);
    ext_en <= 8'hFF;
    ext_val <= e;
    cyc(6);
    rd(`OFS_PIN_VALUE, e & ~a);
    check_pad("analog", a, ana);
    ext_en <= 8'h00;
    wr(`OFS_PULLUP, 8'hFF, 4'h1);
    cyc(6);
    rd(`OFS_PIN_VALUE, ~a);
    end_test("pin read");
    l = 8'($random(seed));
    wr(`OFS_PIN_VALUE, l, 4'h1);
    rd(`OFS_OUT_LATCH, l);
    check_pad("pad enable", 8'h00, pad_oe);
    e = 8'($random(seed));
    wr(`OFS_OUT_LATCH, e, 4'h1);
    rd(`OFS_OUT_LATCH, e);
    wr(`OFS_PIN_VALUE, l, 4'h0);
    rd(`OFS_OUT_LATCH, ~a);
    end_test("latch");
    wr(`OFS_DIRECTION, 8'h00, 4'h1);
    for (int k = 0; k < 2; k++)
    begin
      l = 8'($random(seed));
      o = k ? 8'($random(seed)) : 8'h00;
      e = k ? 8'h00 : 8'($random(seed));
      wr(`OFS_OUT_LATCH, l, 4'h1);
      wr(`OFS_OPEN_DRAIN, o, 4'h1);
      i2c <= e;
      cyc(2);
      @(negedge core_clk_i);
      check_pad("pad enable", ~((o | e) & l), pad_oe);
      check_pad("pad level", l & ~(o | e), pad_out);
      @(posedge core_clk_i);
    end
    end_test("open drain");
    i2c <= 8'h00;
    wr(`OFS_OPEN_DRAIN, 8'h00, 4'h1);
    m = 8'($random(seed));
    e = 8'($random(seed));
    periph <= e;
    wr(`OFS_PERIPH_SEL, m, 4'h1);
    cyc(2);
    @(negedge core_clk_i);
    check_pad("pad level", (m & e) | (~m & l), pad_out);
    @(posedge core_clk_i);
    rd(`OFS_PERIPH_SEL, m);
    end_test("pin mux");
    l = 8'($random(seed));
    m = 8'($random(seed));
    o = 8'($random(seed));
    wr(`OFS_SLEW, l, 4'h1);
    // hand every pin back from the peripherals before thresholds move
    periph <= 8'h00;
    wr(`OFS_PERIPH_SEL, 8'h00, 4'h1);
    wr(`OFS_THRESHOLD, m, 4'h1);
    wr(`OFS_PULLUP, o, 4'h1);
    cyc(2);
    @(negedge core_clk_i);
    check_pad("slew", l, slew);
    check_pad("threshold", m, thr);
    check_pad("pull-up", o, pup);
    @(posedge core_clk_i);
    rd(`OFS_THRESHOLD, m);
    // pin byte lane disabled: the control register must keep its value
    wr(`OFS_SLEW, ~l, 4'hE);
    rd(`OFS_SLEW, l);
    end_test("pad controls");
    cyc(4);
    finish_test();
  end
endmodule : bidirectional_gpio_port_test

// ===== dv/pad_board.sv
module pad_board
(
  input wire logic core_clk_i, // system clock
  input wire logic [7:0] pad_out_i, // device drive level
  input wire logic [7:0] pad_oe_i, // device drive enable
  input wire logic [7:0] pullup_en_i, // device weak pull-up enable
  input wire logic [7:0] ext_en_i, // board drives the pin
  input wire logic [7:0] ext_val_i, // board drive level
  output logic [7:0] pad_in_o // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wander = 8'h55;

  // an undriven pin wanders every cycle so a stale level is never read as valid
  always @(posedge core_clk_i)
  begin
    wander <= ~wander;
  end

  // device driver wins, then the board, then the weak pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_oe_i[i])
        pad_in_o[i] = pad_out_i[i];
      else if (ext_en_i[i])
        pad_in_o[i] = ext_val_i[i];
      else if (pullup_en_i[i])
        pad_in_o[i] = 1'b1;
      else
        pad_in_o[i] = wander[i];
    end
  end
endmodule : pad_board

// ===== rtl/gpio_port.sv
// Implementation choices: the register offsets and register access over AXI4-Lite.
`include "gpio_port_consts.svh"
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS = `PIN_COUNT,
  parameter int ADDR_W = `ADDR_WIDTH,
  parameter int DATA_W = `DATA_WIDTH
)
(
  input wire logic core_clk_i, // system clock, 40 MHz
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [DATA_W-1:0] s_axi_wdata_i, // write data
  input wire logic [DATA_W/8-1:0] s_axi_wstrb_i, // write byte enables
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [DATA_W-1:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic [PINS-1:0] pad_in_i, // pin levels from pads
  output logic [PINS-1:0] pad_out_o, // pad driver level
  output logic [PINS-1:0] pad_oe_o, // pad driver enable
  output logic [PINS-1:0] slew_limit_o, // 1 = slew limited drive
  output logic [PINS-1:0] threshold_ttl_o, // 1 = ttl input threshold
  output logic [PINS-1:0] pullup_en_o, // 1 = weak pull-up on
  output logic [PINS-1:0] analog_en_o, // 1 = pin in analog mode
  input wire logic [PINS-1:0] periph_out_i, // peripheral output levels
  input wire logic [PINS-1:0] i2c_own_i // two-wire bus owns the pin
);

  logic [PINS-1:0] direction_reg;
  logic [PINS-1:0] output_latch_reg;
  logic [PINS-1:0] analog_select;
  logic [PINS-1:0] pullup_enable;
  logic [PINS-1:0] open_drain_ctrl;
  logic [PINS-1:0] slew_limit_ctrl;
  logic [PINS-1:0] input_threshold_sel;
  logic [PINS-1:0] peripheral_pin_mux;
  logic [PINS-1:0] pin_stable;
  logic [PINS-1:0] pin_value_reg;
  logic [PINS-1:0] eff_od;
  logic [PINS-1:0] out_src;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W/8-1:0] w_strb;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_lane;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic [PINS-1:0] rd_value;

  // address decode; anything unaligned or unlisted selects nothing
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    unique case (addr)
      `OFS_PIN_VALUE: sel = SEL_PIN;
      `OFS_DIRECTION: sel = SEL_DIR;
      `OFS_OUT_LATCH: sel = SEL_LAT;
      `OFS_ANALOG_SEL: sel = SEL_ANA;
      `OFS_PULLUP: sel = SEL_PUP;
      `OFS_OPEN_DRAIN: sel = SEL_ODC;
      `OFS_SLEW: sel = SEL_SLR;
      `OFS_THRESHOLD: sel = SEL_THR;
      `OFS_PERIPH_SEL: sel = SEL_MUX;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // pad inputs come from outside the clock domain
  pin_sync #(
    .W(PINS)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pad_in_i),
    .stable_o(pin_stable)
  );

  // analog pins read as zero; the pad already applied the threshold
  assign pin_value_reg = pin_stable & ~analog_select;

  // two-wire ownership forces open drain without touching the control bit
  assign eff_od = open_drain_ctrl | i2c_own_i;

  // latch drives unless the pin mux hands the pin to a peripheral
  assign out_src = (output_latch_reg & ~peripheral_pin_mux)
                 | (periph_out_i & peripheral_pin_mux);

  // one driver per pin; analog select is not an input, so it cannot gate drive
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pad
      pad_drive u_pad_drive (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .dir_i(direction_reg[gi]),
        .od_i(eff_od[gi]),
        .src_i(out_src[gi]),
        .oe_o(pad_oe_o[gi]),
        .out_o(pad_out_o[gi])
      );
    end
  endgenerate

  // static pad controls straight from their registers
  assign slew_limit_o = slew_limit_ctrl;
  assign threshold_ttl_o = input_threshold_sel;
  assign pullup_en_o = pullup_enable;
  assign analog_en_o = analog_select;

  // write channel handshake: address and data may come in either order
  assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_got && !s_axi_bvalid_o;
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
  assign do_write = (aw_got || aw_fire) && (w_got || w_fire);
  assign wr_addr = aw_got ? aw_addr : s_axi_awaddr_i;
  assign wr_data = w_got ? w_data : s_axi_wdata_i;
  assign wr_lane = w_got ? w_strb[`PIN_LANE] : s_axi_wstrb_i[`PIN_LANE];
  assign wr_sel = decode(wr_addr);

  // hold whichever half arrived first until the other one shows up
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (do_write)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (w_fire)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // configuration registers; only the low byte lane carries pin bits
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      direction_reg <= `RST_DIRECTION;
      analog_select <= `RST_ANALOG_SEL;
      pullup_enable <= `RST_PULLUP;
      open_drain_ctrl <= `RST_OPEN_DRAIN;
      slew_limit_ctrl <= `RST_SLEW;
      input_threshold_sel <= `RST_THRESHOLD;
      peripheral_pin_mux <= `RST_PERIPH_SEL;
    end
    else if (do_write && wr_lane)
    begin
      unique case (wr_sel)
        SEL_DIR: direction_reg <= wr_data[PINS-1:0];
        SEL_ANA: analog_select <= wr_data[PINS-1:0];
        SEL_PUP: pullup_enable <= wr_data[PINS-1:0];
        SEL_ODC: open_drain_ctrl <= wr_data[PINS-1:0];
        SEL_SLR: slew_limit_ctrl <= wr_data[PINS-1:0];
        SEL_THR: input_threshold_sel <= wr_data[PINS-1:0];
        SEL_MUX: peripheral_pin_mux <= wr_data[PINS-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // output latch: a pin register write is a read-modify-write, so a
  // disabled byte lane still copies the pins in; analog pins read as 0
  // and will clear their latch bits, a known hazard for software
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      output_latch_reg <= `RST_OUT_LATCH;
    else if (do_write && wr_sel == SEL_LAT && wr_lane)
      output_latch_reg <= wr_data[PINS-1:0];
    else if (do_write && wr_sel == SEL_PIN)
      output_latch_reg <= wr_lane ? wr_data[PINS-1:0] : pin_value_reg;
  end

  // read mux; unused upper bits read as zero
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_sel = decode(s_axi_araddr_i);

  always_comb
  begin
    rd_value = '0;
    unique case (rd_sel)
      SEL_PIN: rd_value = pin_value_reg;
      SEL_DIR: rd_value = direction_reg;
      SEL_LAT: rd_value = output_latch_reg;
      SEL_ANA: rd_value = analog_select;
      SEL_PUP: rd_value = pullup_enable;
      SEL_ODC: rd_value = open_drain_ctrl;
      SEL_SLR: rd_value = slew_limit_ctrl;
      SEL_THR: rd_value = input_threshold_sel;
      SEL_MUX: rd_value = peripheral_pin_mux;
      default: rd_value = '0;
    endcase
  end

  // read data captured one cycle after the address is taken
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= `RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {{(DATA_W-PINS){1'b0}}, rd_value};
      s_axi_rresp_o <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  // inputs never drive
  dir_input_off_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1 |=> ((pad_oe_o & $past(direction_reg)) == '0))
    else $error("driver enabled on an input pin");

  // outputs drive unless open drain releases them, analog or not
  push_pull_drive_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1 |=> ((pad_oe_o | $past(direction_reg | eff_od)) == '1)
          && (((pad_out_o ^ $past(out_src)) & ~$past(direction_reg | eff_od)) == '0))
    else $error("output pin not driving its source value");

  // open drain never drives high
  open_drain_low_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1 |=> ((pad_out_o & $past(open_drain_ctrl)) == '0))
    else $error("open-drain pin driven high");

  // two-wire ownership acts like open drain
  bus_owned_od_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1 |=> ((pad_out_o & $past(i2c_own_i)) == '0)
          && ((pad_oe_o & $past(i2c_own_i & out_src)) == '0))
    else $error("bus-owned pin not open drain");

  // digital read of an analog pin is zero
  analog_read_zero_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ar_fire && rd_sel == SEL_PIN
    |=> s_axi_rvalid_o && ((s_axi_rdata_o[PINS-1:0] & $past(analog_select)) == '0))
    else $error("analog pin read as one");

  // reset state of analog and pull-up bits
  reset_state_a: assert property (
    @(posedge core_clk_i)
    !rst_n_i |=> analog_select == `RST_ANALOG_SEL && pullup_enable == `RST_PULLUP
                 && peripheral_pin_mux == `RST_PERIPH_SEL)
    else $error("wrong reset state");

  // latch register write lands in the latch
  latch_write_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    do_write && wr_sel == SEL_LAT && wr_lane
    |=> output_latch_reg == $past(wr_data[PINS-1:0]))
    else $error("latch write lost");

  // pin register write goes to the latch via read-modify-write
  pin_write_rmw_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    do_write && wr_sel == SEL_PIN
    |=> output_latch_reg == ($past(wr_lane) ? $past(wr_data[PINS-1:0])
                                            : $past(pin_value_reg)))
    else $error("pin register write did not update latch");

  // response comes exactly one cycle after both halves are in
  write_resp_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    do_write |=> s_axi_bvalid_o)
    else $error("write response missing");

  // read data comes exactly one cycle after the address is taken
  read_resp_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ar_fire |=> s_axi_rvalid_o)
    else $error("read data missing");

endmodule : gpio_port

// ===== rtl/gpio_port_consts.svh
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// port geometry and bus widths
`define PIN_COUNT 8
`define ADDR_WIDTH 6
`define DATA_WIDTH 32

// register byte offsets on the bus
`define OFS_PIN_VALUE 6'h00
`define OFS_DIRECTION 6'h04
`define OFS_OUT_LATCH 6'h08
`define OFS_ANALOG_SEL 6'h0C
`define OFS_PULLUP 6'h10
`define OFS_OPEN_DRAIN 6'h14
`define OFS_SLEW 6'h18
`define OFS_THRESHOLD 6'h1C
`define OFS_PERIPH_SEL 6'h20

// reset values of the control registers
`define RST_DIRECTION 8'hFF
`define RST_OUT_LATCH 8'h00
`define RST_ANALOG_SEL 8'hFF
`define RST_PULLUP 8'h00
`define RST_OPEN_DRAIN 8'h00
`define RST_SLEW 8'h00
`define RST_THRESHOLD 8'h00
`define RST_PERIPH_SEL 8'h00

// bus response codes and byte lane of the pin bits
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PIN_LANE 0

`endif

// ===== rtl/gpio_port_pkg.sv
package gpio_port_pkg;

  // register selected by a bus address
  typedef enum logic [3:0]
  {
    SEL_NONE,
    SEL_PIN,
    SEL_DIR,
    SEL_LAT,
    SEL_ANA,
    SEL_PUP,
    SEL_ODC,
    SEL_SLR,
    SEL_THR,
    SEL_MUX
  } reg_sel_t;

endpackage : gpio_port_pkg

// ===== rtl/pad_drive.sv
module pad_drive
(
  input wire logic core_clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic dir_i, // 1 = input, driver off
  input wire logic od_i, // open-drain in effect
  input wire logic src_i, // value to drive
  output logic oe_o, // pad driver enable
  output logic out_o // pad driver level
);

  logic next_oe;
  logic next_out;

  // open drain only ever sinks, so a high level turns the driver off
  always_comb
  begin
    next_oe = !dir_i && !(od_i && src_i);
    next_out = src_i && !od_i;
  end

  // registered so the pad never sees decode glitches
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      oe_o <= 1'b0;
      out_o <= 1'b0;
    end
    else
    begin
      oe_o <= next_oe;
      out_o <= next_out;
    end
  end

endmodule : pad_drive

// ===== rtl/pin_sync.sv
module pin_sync
#(
  parameter int W = 8
)
(
  input wire logic core_clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [W-1:0] async_i, // raw pad levels
  output logic [W-1:0] stable_o // filtered level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // three stages; s1 feeds only s2 so metastability never reaches logic
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once the two settled stages agree
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      stable_o <= '0;
    else
      stable_o <= (s2 & s3) | (stable_o & (s2 | s3));
  end

endmodule : pin_sync
